// File: src/spm_pkg.sv
package spm_pkg;
	// core address fields
	localparam int CORE_ADDR_W     = 32;
	localparam int BANK_CORE_HI    = 25;
	localparam int BANK_CORE_LO    = 21;
	localparam int IBANK_CORE_HI   = 12;
	localparam int IBANK_CORE_LO   = 9;
	// external address line positions
	localparam int EXT_ADDR_W      = 25;
	localparam int BANK_EXT_HI     = 15;
	localparam int BANK_EXT_LO     = 11;
	localparam int IBANK_EXT_HI    = 19;
	localparam int IBANK_EXT_LO    = 16;
	localparam int RC_EXT_HI       = 10;
	localparam int RC_EXT_LO       = 1;
	// sdram address and data mask widths
	localparam int BANK_W          = 5;
	localparam int IBANK_W         = 4;
	localparam int RC_W            = 12;
	localparam int RC_SHARED_W     = 10;
	localparam int DQM_W           = 4;
	// function mux control: bit 0 gives pin two, bit 1 pin three, to the dram selects
	localparam int FMC_W           = 2;
	localparam logic [1:0] FMC_RESET = 2'h3;
	localparam int FMC_SEL0_BIT    = 0;
	localparam int FMC_SEL1_BIT    = 1;
	// pin reset levels
	localparam logic [EXT_ADDR_W-1:0] EXT_ADDR_RESET = 25'h0000000;
	localparam logic [1:0]            RC_HI_RESET    = 2'h0;
	localparam logic                  SELECT_IDLE    = 1'h1;
	localparam logic                  STROBE_IDLE    = 1'h1;
	localparam logic                  CKE_RESET      = 1'h0;
	localparam logic                  DRAM_CLK_RESET = 1'h0;
	localparam logic [DQM_W-1:0]      DQM_RESET      = 4'hF;
endpackage

// File: src/spm_sdram_pin_mux.sv
`timescale 1ns/100ps
// Operation
// [R1] non-interleave: bank lines from core 25:21
// [R2] interleave: bank lines from core 12:9; the code keeps lines 15:11 from core 25:21 and puts core 12:9 on lines 19:16
// [R3] row/column on lines 10:1 only in sdram cycles
// [R4] select zero pin chosen by mux control
// [R5] select one defaults to dram after reset
// [R6] mux control register defaults to dram selects
// [R7] drive standard sdram command pins
module spm_sdram_pin_mux
	import spm_pkg::*;
(
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   arst_n,
	// system control
	input  wire logic                   fmc_write,
	input  wire logic [FMC_W-1:0]       fmc_wdata,
	output logic      [FMC_W-1:0]       function_mux_control,
	// core side address and cycle
	input  wire logic [CORE_ADDR_W-1:0] core_addr,
	input  wire logic [EXT_ADDR_W-1:0]  gen_addr,
	input  wire logic                   sdram_cycle,
	input  wire logic                   interleave_mode,
	input  wire logic [RC_W-1:0]        sdram_rc_addr,
	// static selects from the external bus unit, active low
	input  wire logic                   static_two_n,
	input  wire logic                   static_three_n,
	// sdram controller commands, active low where named
	input  wire logic                   sd_cs0_n,
	input  wire logic                   sd_cs1_n,
	input  wire logic                   sd_ras_n,
	input  wire logic                   sd_cas_n,
	input  wire logic                   sd_we_n,
	input  wire logic                   sd_cke0,
	input  wire logic                   sd_cke1,
	input  wire logic                   sd_clk_en,
	input  wire logic [DQM_W-1:0]       sd_dqm,
	// pins
	output logic      [EXT_ADDR_W-1:0]  ext_addr,
	output logic      [1:0]             row_column_hi,
	output logic                        select_two_pin_n,
	output logic                        select_three_pin_n,
	output logic                        row_strobe_n,
	output logic                        column_strobe_n,
	output logic                        dram_write_enable_n,
	output logic                        dram_clock_enable_zero,
	output logic                        dram_clock_enable_one,
	output logic                        dram_clock,
	output logic      [DQM_W-1:0]       data_mask
);
	logic                  rst_n;
	logic [FMC_W-1:0]      next_function_mux_control;
	logic [EXT_ADDR_W-1:0] next_ext_addr;
	logic [1:0]            next_row_column_hi;
	logic                  next_select_two_n;
	logic                  next_select_three_n;
	logic                  next_dram_clock;

	// pin owner: dram select when its mux bit is set
	function automatic logic pick_select(
		input logic dram_owns,
		input logic dram_sel_n,
		input logic static_sel_n
	);
		return dram_owns ? dram_sel_n : static_sel_n;
	endfunction

	spm_sync u_sync (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.rst_n    (rst_n)
	);

	// mux control next value
	always_comb begin
		next_function_mux_control = function_mux_control;
		if (fmc_write) begin
			next_function_mux_control = fmc_wdata; // [R6]
		end
	end

	// mux control register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			function_mux_control <= FMC_RESET; // [R6] [R5]
		end else begin
			function_mux_control <= next_function_mux_control; // [R6]
		end
	end

	// address routing
	always_comb begin
		next_ext_addr = gen_addr;
		if (sdram_cycle) begin
			next_ext_addr[RC_EXT_HI:RC_EXT_LO] = sdram_rc_addr[RC_SHARED_W-1:0]; // [R3]
			next_ext_addr[BANK_EXT_HI:BANK_EXT_LO] =
				core_addr[BANK_CORE_HI:BANK_CORE_LO]; // [R1]
			if (interleave_mode) begin
				next_ext_addr[IBANK_EXT_HI:IBANK_EXT_LO] =
					core_addr[IBANK_CORE_HI:IBANK_CORE_LO]; // [R2]
			end
		end
	end

	// dedicated row/column high lines
	always_comb begin
		next_row_column_hi = sdram_rc_addr[RC_W-1:RC_SHARED_W]; // [R3]
	end

	// shared address lines
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_addr <= EXT_ADDR_RESET;
		end else begin
			ext_addr <= next_ext_addr; // [R1] [R2] [R3]
		end
	end

	// row/column high register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			row_column_hi <= RC_HI_RESET;
		end else begin
			row_column_hi <= next_row_column_hi; // [R3]
		end
	end

	// owner of select pin two
	always_comb begin
		next_select_two_n = pick_select(function_mux_control[FMC_SEL0_BIT],
			sd_cs0_n, static_two_n); // [R4]
	end

	// owner of select pin three
	always_comb begin
		next_select_three_n = pick_select(function_mux_control[FMC_SEL1_BIT],
			sd_cs1_n, static_three_n); // [R5]
	end

	// select pin two
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			select_two_pin_n <= SELECT_IDLE;
		end else begin
			select_two_pin_n <= next_select_two_n; // [R4]
		end
	end

	// select pin three
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			select_three_pin_n <= SELECT_IDLE;
		end else begin
			select_three_pin_n <= next_select_three_n; // [R5]
		end
	end

	// row strobe pin
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			row_strobe_n <= STROBE_IDLE;
		end else begin
			row_strobe_n <= sd_ras_n; // [R7]
		end
	end

	// column strobe pin
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			column_strobe_n <= STROBE_IDLE;
		end else begin
			column_strobe_n <= sd_cas_n; // [R7]
		end
	end

	// write enable pin
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dram_write_enable_n <= STROBE_IDLE;
		end else begin
			dram_write_enable_n <= sd_we_n; // [R7]
		end
	end

	// clock enable zero pin
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dram_clock_enable_zero <= CKE_RESET;
		end else begin
			dram_clock_enable_zero <= sd_cke0; // [R7]
		end
	end

	// clock enable one pin
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dram_clock_enable_one <= CKE_RESET;
		end else begin
			dram_clock_enable_one <= sd_cke1; // [R7]
		end
	end

	// divided memory clock, parked low when off
	always_comb begin
		if (sd_clk_en) begin
			next_dram_clock = ~dram_clock; // [R7]
		end else begin
			next_dram_clock = DRAM_CLK_RESET;
		end
	end

	// memory clock pin
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dram_clock <= DRAM_CLK_RESET;
		end else begin
			dram_clock <= next_dram_clock; // [R7]
		end
	end

	// byte lane masks
	for (genvar lane = 0; lane < DQM_W; lane++) begin : g_mask
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				data_mask[lane] <= DQM_RESET[lane];
			end else begin
				data_mask[lane] <= sd_dqm[lane]; // [R7]
			end
		end
	end
endmodule

// File: src/spm_sync.sv
`timescale 1ns/100ps
module spm_sync
	import spm_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic arst_n,
	// reset copy
	output logic      rst_n
);
	logic stage;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stage <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			stage <= 1'b1;
			rst_n <= stage;
		end
	end
endmodule

// File: testbench/sdram_pin_address_mux_bench.sv
`timescale 1ns/100ps
module sdram_pin_address_mux_bench;
	import spm_pkg::*;
	logic clk=0,rn=0,fw=0,sc=0,im=0,s2=1,s3=1,c0=1,c1=1,ra=1,ca=1,we=1,k0=0,k1=0,ce=0;
	logic [1:0] fd=0,fmc,rh;
	logic [31:0] a=0;
	logic [24:0] g=0,ea;
	logic [11:0] r=0;
	logic [3:0] m=0,dm;
	logic [7:0] acts;
	logic p2,p3,rs,cs,wo,e0,e1,dc;
	logic v;
	int num_errors=0,n_checks=0;
	always #5 clk = ~clk;
	spm_sdram_pin_mux dut (.core_clk(clk),.arst_n(rn),.fmc_write(fw),.fmc_wdata(fd),
		.function_mux_control(fmc),.core_addr(a),.gen_addr(g),.sdram_cycle(sc),
		.interleave_mode(im),.sdram_rc_addr(r),.static_two_n(s2),.static_three_n(s3),
		.sd_cs0_n(c0),.sd_cs1_n(c1),.sd_ras_n(ra),.sd_cas_n(ca),.sd_we_n(we),.sd_cke0(k0),
		.sd_cke1(k1),.sd_clk_en(ce),.sd_dqm(m),.ext_addr(ea),.row_column_hi(rh),
		.select_two_pin_n(p2),.select_three_pin_n(p3),.row_strobe_n(rs),.column_strobe_n(cs),
		.dram_write_enable_n(wo),.dram_clock_enable_zero(e0),.dram_clock_enable_one(e1),
		.dram_clock(dc),.data_mask(dm));
	spm_sdram_model sdram (.dram_clock(dc),.cs_n(p2),.ras_n(rs),.cas_n(cs),.we_n(wo),.acts(acts));
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %0t %h %h", $time, s, e);
		end
	endtask
	task test_done;
		if (num_errors == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task nx;
		@(negedge clk);
	endtask
	task t_sel;
		chk(fmc, 2'h3);
		c1 = 0;
		c0 = 0;
		nx;
		chk(p3, 1'b0);
		for (int i = 0; i < 4; i++) begin
			fd = 2'(i);
			fw = 1;
			nx;
			fw = 0;
			chk(fmc, i);
			nx;
			chk(p2, !i[0]);
			chk(p3, !i[1]);
		end
	endtask
	task t_addr;
		a = 32'h03E0_1E00;
		g = 25'h0AA_AAAA;
		r = 12'hA55;
		sc = 1;
		nx;
		chk(ea[15:11], 5'h1F);
		chk(ea[10:1], 10'h255);
		chk(ea[19:16], 4'hA);
		chk(rh, 2'h2);
		im = 1;
		nx;
		chk(ea[19:16], 4'hF);
		chk(ea[15:11], 5'h1F);
		sc = 0;
		nx;
		chk(ea, g);
	endtask
	task t_cmd;
		ce = 1;
		m = 4'h5;
		ra = 0;
		nx;
		nx;
		ra = 1;
		chk(dm, 4'h5);
		repeat (3) nx;
		chk(acts, 8'h01);
		ca = 0;
		we = 0;
		k0 = 1;
		k1 = 1;
		nx;
		chk(cs, 1'b0);
		chk(wo, 1'b0);
		chk(e0, 1'b1);
		chk(e1, 1'b1);
		v = dc;
		nx;
		chk(dc, !v);
		ce = 0;
		ca = 1;
		we = 1;
		nx;
		chk(dc, 1'b0);
		chk(acts, 8'h01);
	endtask
	task t_rst;
		fd = 2'h0;
		fw = 1;
		nx;
		fw = 0;
		chk(fmc, 2'h0);
		rn = 0;
		nx;
		chk(fmc, 2'h3);
		chk(p3, 1'b1);
		chk(dm, 4'hF);
		chk(e0, 1'b0);
		rn = 1;
		nx;
		nx;
		chk(p3, 1'b1);
		nx;
		chk(p3, 1'b0);
		chk(fmc, 2'h3);
	endtask
	initial begin
		#20000;
		num_errors++;
		test_done;
	end
	initial begin
		repeat (2) nx;
		rn = 1;
		repeat (3) nx;
		t_sel;
		t_addr;
		t_cmd;
		t_rst;
		test_done;
	end
endmodule

// File: testbench/spm_pin_mux_assertions.sv
`timescale 1ns/100ps
module spm_pin_mux_assertions
	import spm_pkg::*;
(
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   arst_n,
	// system control
	input  wire logic                   fmc_write,
	input  wire logic [FMC_W-1:0]       fmc_wdata,
	input  wire logic [FMC_W-1:0]       function_mux_control,
	// address
	input  wire logic [CORE_ADDR_W-1:0] core_addr,
	input  wire logic [EXT_ADDR_W-1:0]  gen_addr,
	input  wire logic                   sdram_cycle,
	input  wire logic                   interleave_mode,
	input  wire logic [RC_W-1:0]        sdram_rc_addr,
	// selects and commands in
	input  wire logic                   static_two_n,
	input  wire logic                   static_three_n,
	input  wire logic                   sd_cs0_n,
	input  wire logic                   sd_cs1_n,
	input  wire logic                   sd_ras_n,
	input  wire logic                   sd_cas_n,
	input  wire logic                   sd_we_n,
	input  wire logic                   sd_cke0,
	input  wire logic                   sd_cke1,
	input  wire logic                   sd_clk_en,
	input  wire logic [DQM_W-1:0]       sd_dqm,
	// pins
	input  wire logic [EXT_ADDR_W-1:0]  ext_addr,
	input  wire logic [1:0]             row_column_hi,
	input  wire logic                   select_two_pin_n,
	input  wire logic                   select_three_pin_n,
	input  wire logic                   row_strobe_n,
	input  wire logic                   column_strobe_n,
	input  wire logic                   dram_write_enable_n,
	input  wire logic                   dram_clock_enable_zero,
	input  wire logic                   dram_clock_enable_one,
	input  wire logic                   dram_clock,
	input  wire logic [DQM_W-1:0]       data_mask
);
	logic [1:0] up;

	// edges since reset release
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			up <= 2'h0;
		end else if (up != 2'h3) begin
			up <= up + 2'h1;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	bank_map_a: assert property (up == 2'h3 && sdram_cycle |=>
		ext_addr[15:11] == $past(core_addr[25:21])) else $error("bank lines wrong");
	ibank_map_a: assert property (up == 2'h3 && sdram_cycle && interleave_mode |=>
		ext_addr[19:16] == $past(core_addr[12:9])) else $error("interleave lines wrong");
	rc_map_a: assert property (up == 2'h3 |=>
		ext_addr[10:1] == ($past(sdram_cycle) ? $past(sdram_rc_addr[9:0]) :
		$past(gen_addr[10:1]))) else $error("row column lines wrong");
	rc_high_a: assert property (up == 2'h3 |=>
		row_column_hi == $past(sdram_rc_addr[11:10])) else $error("row column high wrong");
	sel_two_a: assert property (up == 2'h3 |=>
		select_two_pin_n == ($past(function_mux_control[0]) ? $past(sd_cs0_n) :
		$past(static_two_n))) else $error("select two pin wrong");
	sel_three_a: assert property (up == 2'h3 |=>
		select_three_pin_n == ($past(function_mux_control[1]) ? $past(sd_cs1_n) :
		$past(static_three_n))) else $error("select three pin wrong");
	mux_reset_a: assert property (up != 2'h3 |-> function_mux_control == FMC_RESET)
		else $error("mux control not at reset value");
	mux_load_a: assert property (up == 2'h3 && fmc_write |=>
		function_mux_control == $past(fmc_wdata)) else $error("mux control load wrong");
	cmd_pins_a: assert property (up == 2'h3 |=>
		row_strobe_n == $past(sd_ras_n) && column_strobe_n == $past(sd_cas_n) &&
		dram_write_enable_n == $past(sd_we_n)) else $error("command strobes wrong");
	clk_enables_a: assert property (up == 2'h3 |=>
		dram_clock_enable_zero == $past(sd_cke0) && dram_clock_enable_one == $past(sd_cke1) &&
		data_mask == $past(sd_dqm)) else $error("clock enables or masks wrong");
	dram_clock_a: assert property (up == 2'h3 |=>
		dram_clock == ($past(sd_clk_en) ? !$past(dram_clock) : 1'b0))
		else $error("memory clock wrong");
endmodule
bind spm_sdram_pin_mux spm_pin_mux_assertions u_chk (
	.core_clk               (core_clk),
	.arst_n                 (arst_n),
	.fmc_write              (fmc_write),
	.fmc_wdata              (fmc_wdata),
	.function_mux_control   (function_mux_control),
	.core_addr              (core_addr),
	.gen_addr               (gen_addr),
	.sdram_cycle            (sdram_cycle),
	.interleave_mode        (interleave_mode),
	.sdram_rc_addr          (sdram_rc_addr),
	.static_two_n           (static_two_n),
	.static_three_n         (static_three_n),
	.sd_cs0_n               (sd_cs0_n),
	.sd_cs1_n               (sd_cs1_n),
	.sd_ras_n               (sd_ras_n),
	.sd_cas_n               (sd_cas_n),
	.sd_we_n                (sd_we_n),
	.sd_cke0                (sd_cke0),
	.sd_cke1                (sd_cke1),
	.sd_clk_en              (sd_clk_en),
	.sd_dqm                 (sd_dqm),
	.ext_addr               (ext_addr),
	.row_column_hi          (row_column_hi),
	.select_two_pin_n       (select_two_pin_n),
	.select_three_pin_n     (select_three_pin_n),
	.row_strobe_n           (row_strobe_n),
	.column_strobe_n        (column_strobe_n),
	.dram_write_enable_n    (dram_write_enable_n),
	.dram_clock_enable_zero (dram_clock_enable_zero),
	.dram_clock_enable_one  (dram_clock_enable_one),
	.dram_clock             (dram_clock),
	.data_mask              (data_mask)
);

// File: testbench/spm_sdram_model.sv
`timescale 1ns/100ps
module spm_sdram_model (
	// command pins seen by the memory
	input  wire logic       dram_clock,
	input  wire logic       cs_n,
	input  wire logic       ras_n,
	input  wire logic       cas_n,
	input  wire logic       we_n,
	// activate count
	output logic      [7:0] acts
);
	initial acts = 8'h00;

	// count activate commands just after each rising clock
	always @(posedge dram_clock) begin
		#1;
		if (!cs_n && !ras_n && cas_n && we_n) begin
			acts = acts + 8'h01;
		end
	end
endmodule
